//--- pkg/cmb_pkg.sv
package cmb_pkg;
	// Buffer geometry, in 16-bit words
	localparam int unsigned WORDS_PER_BUF = 8;
	localparam int unsigned WIDX_W        = 3;
	localparam int unsigned BIDX_W        = 5;
	localparam int unsigned MAX_BUFS      = 32;
	localparam int unsigned MEM_AW        = 10;

	// Word indices inside one message buffer
	localparam logic [2:0] W_STD_ID  = 3'h0;
	localparam logic [2:0] W_EXT_HI  = 3'h1;
	localparam logic [2:0] W_EXT_LO  = 3'h2;
	localparam logic [2:0] W_DATA_01 = 3'h3;
	localparam logic [2:0] W_DATA_67 = 3'h6;
	localparam logic [2:0] W_FHIT    = 3'h7;

	// Field widths and padding of each word
	localparam int unsigned STD_ID_W   = 11;
	localparam int unsigned EXT_ID_W   = 18;
	localparam int unsigned EXT_LO_W   = 6;
	localparam int unsigned DLC_W      = 4;
	localparam int unsigned FHIT_W     = 5;
	localparam int unsigned DATA_W     = 64;
	localparam logic [2:0]  W0_PAD     = 3'h0;
	localparam logic [3:0]  W1_PAD     = 4'h0;
	localparam logic [2:0]  W2_PAD     = 3'h0;
	localparam logic        RSV_ZERO   = 1'b0;
	localparam logic [2:0]  W7_PAD_HI  = 3'h0;
	localparam logic [7:0]  W7_PAD_LO  = 8'h00;

	typedef struct packed {
		logic [BIDX_W-1:0]   buf_idx;
		logic [FHIT_W-1:0]   filter_match_code;
		logic [STD_ID_W-1:0] std_id;
		logic [EXT_ID_W-1:0] ext_id;
		logic                subst_remote_req;
		logic                ext_id_flag;
		logic                rtr;
		logic [DLC_W-1:0]    dlc;
		logic [DATA_W-1:0]   data;   // Byte k at data[8k+7:8k]
	} cmb_frame_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_STORE = 2'b01,
		ST_FETCH = 2'b10
	} cmb_state_t;
endpackage

//--- pkg/cmb_stream_if.sv
`timescale 1ns/1ps
interface cmb_stream_if;
	import cmb_pkg::*;
	logic       valid;
	logic       ready;
	cmb_frame_t data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

//--- design/cmb_skid_buf.sv
`timescale 1ns/1ps
module cmb_skid_buf (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic arst_n,
	// Frames in and out
	cmb_stream_if.snk in_s,
	cmb_stream_if.src out_s
);
	import cmb_pkg::*;

	cmb_frame_t mem_q [2];
	logic       wr_ptr_q;
	logic       rd_ptr_q;
	logic [1:0] cnt_q;
	logic [1:0] cnt_d;
	logic       push;
	logic       pop;
	logic       rdy_q;

	assign push      = in_s.valid && rdy_q;
	assign pop       = out_s.valid && out_s.ready;
	assign out_s.valid = cnt_q != 2'h0;
	assign out_s.data  = mem_q[rd_ptr_q];
	assign in_s.ready  = rdy_q;

	always_comb begin
		cnt_d = cnt_q;
		if (push && !pop) begin
			cnt_d = cnt_q + 2'h1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 2'h1;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q    <= 2'h0;
			rdy_q    <= 1'b1;
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			rdy_q <= cnt_d != 2'h2;
			if (push) begin
				wr_ptr_q <= ~wr_ptr_q;
			end
			if (pop) begin
				rd_ptr_q <= ~rd_ptr_q;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_s.data;
		end
	end

	a_no_overfill: assert property (@(posedge core_clk) // [R13]
		disable iff (!arst_n)
		cnt_q <= 2'h2 && rdy_q == (cnt_q != 2'h2))
		else $error("skid buffer fill level and ready disagree");
endmodule // cmb_skid_buf

//--- design/cmb_msg_buffer.sv
`timescale 1ns/1ps
// Operation
// R1 - Software places buffers in shared memory and picks their base and size; here only buf_base is set, size is fixed at 8 words.
// R2 - Word 0 holds std_id at 12-2; bits 15-13 are zero.
// R3 - Word 0 bit 1 is subst_remote_req: one requests remote transmission.
// R4 - Word 0 bit 0 is ext_id_flag: one selects the extended identifier.
// R5 - ext_id 17-6 in word 1 bits 11-0, 5-0 in word 2 bits 15-10.
// R6 - Word 2 bit 9 holds the remote transmission request flag.
// R7 - Software writes word 2 bits 8 and 4 as zero.
// R8 - DLC sits in word 2 bits 3-0; bits 7-5 are zero.
// R9 - Words 3-6 hold byte pairs: even byte low, odd byte high.
// R10 - Received buffers get filter_match_code in word 7 bits 12-8, rest zero.
// R11 - buffer_direction_select one means transmit buffer, zero receive.
// R12 - Storing into a buffer sets its buffer_full_flag until software clears.
// R13 - Transmit frames read from buffers; received frames stored in same layout.
module cmb_msg_buffer #(
	parameter int unsigned NBUF = 32
) (
	// Clock and reset
	input  wire logic                          core_clk,
	input  wire logic                          arst_n,
	// Configuration from software
	input  wire logic [cmb_pkg::MEM_AW-1:0]    buf_base,
	input  wire logic [NBUF-1:0]               buffer_direction_select,
	input  wire logic                          full_wr,
	input  wire logic [NBUF-1:0]               full_wdata,
	output logic      [NBUF-1:0]               buffer_full_flag,
	// Received frames from the protocol engine
	input  wire logic                          rx_valid,
	input  wire cmb_pkg::cmb_frame_t           rx_frame,
	output logic                               rx_ready,
	// Transmit requests and fetched frames
	input  wire logic                          tx_req,
	input  wire logic [cmb_pkg::BIDX_W-1:0]    tx_buf,
	output logic                               tx_taken,
	output logic                               tx_refused,
	output logic                               tx_frame_valid,
	output cmb_pkg::cmb_frame_t                tx_frame,
	input  wire logic                          tx_frame_ready,
	// Shared message memory port
	output logic                               mem_req,
	output logic                               mem_we,
	output logic      [cmb_pkg::MEM_AW-1:0]    mem_addr,
	output logic      [15:0]                   mem_wdata,
	input  wire logic [15:0]                   mem_rdata,
	input  wire logic                          mem_ack
);
	import cmb_pkg::*;

	if (NBUF < 1 || NBUF > MAX_BUFS) begin : g_chk
		$error("NBUF must lie between 1 and 32");
	end

	cmb_stream_if rx_in ();
	cmb_stream_if rx_q ();

	cmb_state_t        state_q;
	logic [WIDX_W-1:0] wcnt_q;
	logic [BIDX_W-1:0] cur_buf_q;
	logic [NBUF-1:0]   full_q;
	logic [NBUF-1:0]   clr_mask;
	logic              store_done;
	logic              fetch_last;
	logic              tx_frame_valid_q;
	cmb_frame_t        tx_frame_q;
	logic              tx_taken_q;
	logic              tx_refused_q;
	logic              mem_req_q;
	logic              mem_we_q;
	logic [MEM_AW-1:0] mem_addr_q;
	logic [15:0]       mem_wdata_q;

	assign rx_in.valid = rx_valid;
	assign rx_in.data  = rx_frame;

	cmb_skid_buf u_rx_buf (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.in_s     (rx_in),
		.out_s    (rx_q)
	);

	// Word address of word w in buffer b
	function automatic logic [MEM_AW-1:0] buf_addr(
		input logic [MEM_AW-1:0] base,
		input logic [BIDX_W-1:0] b,
		input logic [WIDX_W-1:0] w
	);
		buf_addr = base + MEM_AW'({b, w});
	endfunction

	// One buffer word of a received frame, unimplemented bits zero
	function automatic logic [15:0] pack_word(
		input cmb_frame_t        f,
		input logic [WIDX_W-1:0] w
	);
		case (w)
			W_STD_ID: pack_word = {W0_PAD, f.std_id,              // [R2]
				f.subst_remote_req, f.ext_id_flag};           // [R3] [R4]
			W_EXT_HI: pack_word = {W1_PAD,
				f.ext_id[EXT_ID_W-1:EXT_LO_W]};               // [R5]
			W_EXT_LO: pack_word = {f.ext_id[EXT_LO_W-1:0], f.rtr, // [R5] [R6]
				RSV_ZERO, W2_PAD, RSV_ZERO, f.dlc};           // [R8]
			W_FHIT: pack_word = {W7_PAD_HI, f.filter_match_code,  // [R10]
				W7_PAD_LO};
			default: pack_word = f.data[16*(32'(w)-32'(W_DATA_01)) +: 16]; // [R9]
		endcase
	endfunction

	assign store_done = state_q == ST_STORE && mem_ack && wcnt_q == W_FHIT;
	assign fetch_last = state_q == ST_FETCH && mem_ack && wcnt_q == W_DATA_67;
	assign rx_q.ready = store_done;
	assign rx_ready   = rx_in.ready;
	assign clr_mask   = full_wr ? ~full_wdata : '0;

	// Sequencer: stores take priority over fetches
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q      <= ST_IDLE;
			wcnt_q       <= '0;
			cur_buf_q    <= '0;
			mem_req_q    <= 1'b0;
			mem_we_q     <= 1'b0;
			mem_addr_q   <= '0;
			mem_wdata_q  <= '0;
			tx_taken_q   <= 1'b0;
			tx_refused_q <= 1'b0;
		end else begin
			tx_taken_q   <= 1'b0;
			tx_refused_q <= 1'b0;
			unique case (state_q)
				ST_IDLE: begin
					wcnt_q <= '0;
					if (rx_q.valid) begin
						state_q     <= ST_STORE;                     // [R13]
						mem_req_q   <= 1'b1;
						mem_we_q    <= 1'b1;
						mem_addr_q  <= buf_addr(buf_base, rx_q.data.buf_idx, W_STD_ID);
						mem_wdata_q <= pack_word(rx_q.data, W_STD_ID);
					end else if (tx_req && !tx_frame_valid_q) begin
						if (buffer_direction_select[tx_buf]) begin // [R11]
							state_q    <= ST_FETCH;
							cur_buf_q  <= tx_buf;
							tx_taken_q <= 1'b1;
							mem_req_q  <= 1'b1;
							mem_we_q   <= 1'b0;
							mem_addr_q <= buf_addr(buf_base, tx_buf, W_STD_ID);
						end else begin
							tx_refused_q <= 1'b1;
						end
					end
				end
				ST_STORE: begin
					if (mem_ack) begin
						if (wcnt_q == W_FHIT) begin
							state_q   <= ST_IDLE;
							mem_req_q <= 1'b0;
						end else begin
							wcnt_q      <= wcnt_q + 3'h1;            // [R13]
							mem_addr_q  <= buf_addr(buf_base, rx_q.data.buf_idx,
								wcnt_q + 3'h1);
							mem_wdata_q <= pack_word(rx_q.data, wcnt_q + 3'h1);
						end
					end
				end
				ST_FETCH: begin
					if (mem_ack) begin
						if (wcnt_q == W_DATA_67) begin
							state_q   <= ST_IDLE;
							mem_req_q <= 1'b0;
						end else begin
							wcnt_q     <= wcnt_q + 3'h1;
							mem_addr_q <= buf_addr(buf_base, cur_buf_q,
								wcnt_q + 3'h1);
						end
					end
				end
			endcase
		end
	end

	// Unpack fetched words; unimplemented and reserved bits are ignored
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_frame_q       <= '0;
			tx_frame_valid_q <= 1'b0;
		end else begin
			if (fetch_last) begin
				tx_frame_valid_q <= 1'b1;
			end else if (tx_frame_ready) begin
				tx_frame_valid_q <= 1'b0;
			end
			if (state_q == ST_FETCH && mem_ack) begin
				tx_frame_q.buf_idx           <= cur_buf_q;
				tx_frame_q.filter_match_code <= '0;               // [R10]
				case (wcnt_q)
					W_STD_ID: begin
						tx_frame_q.std_id           <= mem_rdata[12:2]; // [R2]
						tx_frame_q.subst_remote_req <= mem_rdata[1];    // [R3]
						tx_frame_q.ext_id_flag      <= mem_rdata[0];    // [R4]
					end
					W_EXT_HI: tx_frame_q.ext_id[EXT_ID_W-1:EXT_LO_W]
						<= mem_rdata[11:0];                        // [R5]
					W_EXT_LO: begin
						tx_frame_q.ext_id[EXT_LO_W-1:0] <= mem_rdata[15:10];
						tx_frame_q.rtr <= mem_rdata[9];                 // [R6]
						tx_frame_q.dlc <= mem_rdata[3:0];              // [R8] [R7]
					end
					default: tx_frame_q.data[16*(32'(wcnt_q)-32'(W_DATA_01)) +: 16]
						<= mem_rdata;                              // [R9]
				endcase
			end
		end
	end

	// Set wins over a software clear in the same cycle
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			full_q <= '0;
		end else begin
			for (int i = 0; i < NBUF; i++) begin
				if (store_done && 32'(rx_q.data.buf_idx) == i) begin
					full_q[i] <= 1'b1;                                 // [R12]
				end else if (clr_mask[i]) begin
					full_q[i] <= 1'b0;
				end
			end
		end
	end

	assign buffer_full_flag = full_q;
	assign tx_taken         = tx_taken_q;
	assign tx_refused       = tx_refused_q;
	assign tx_frame_valid   = tx_frame_valid_q;
	assign tx_frame         = tx_frame_q;
	assign mem_req          = mem_req_q;
	assign mem_we           = mem_we_q;
	assign mem_addr         = mem_addr_q;
	assign mem_wdata        = mem_wdata_q;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	logic st_wr;
	assign st_wr = mem_req_q && mem_we_q;

	sequence s_store_last;
		state_q == ST_STORE && mem_ack && wcnt_q == W_FHIT;
	endsequence
	sequence s_fetch_last;
		state_q == ST_FETCH && mem_ack && wcnt_q == W_DATA_67;
	endsequence

	a_w0_std_id: assert property (st_wr && wcnt_q == W_STD_ID |-> // [R2]
		mem_wdata_q[15:13] == 3'h0 && mem_wdata_q[12:2] == rx_q.data.std_id)
		else $error("word 0 identifier packing wrong");
	a_w0_srr_bit: assert property (st_wr && wcnt_q == W_STD_ID |-> // [R3]
		mem_wdata_q[1] == rx_q.data.subst_remote_req)
		else $error("word 0 bit 1 wrong");
	a_w0_ide_bit: assert property (st_wr && wcnt_q == W_STD_ID |-> // [R4]
		mem_wdata_q[0] == rx_q.data.ext_id_flag)
		else $error("word 0 bit 0 wrong");
	a_ext_id_split: assert property (st_wr && wcnt_q == W_EXT_HI |-> // [R5]
		mem_wdata_q[15:12] == 4'h0 && mem_wdata_q[11:0] == rx_q.data.ext_id[17:6]
		##[1:300] (st_wr && wcnt_q == W_EXT_LO &&
		mem_wdata_q[15:10] == rx_q.data.ext_id[5:0]))
		else $error("extended identifier split wrong");
	a_w2_rtr_dlc: assert property (st_wr && wcnt_q == W_EXT_LO |-> // [R6] [R8]
		mem_wdata_q[9] == rx_q.data.rtr && mem_wdata_q[8:4] == 5'h00 &&
		mem_wdata_q[3:0] == rx_q.data.dlc)
		else $error("word 2 flags or length wrong");
	a_data_pairs: assert property (st_wr && wcnt_q == W_DATA_01 |-> // [R9]
		mem_wdata_q == {rx_q.data.data[15:8], rx_q.data.data[7:0]})
		else $error("data byte pairing wrong");
	a_w7_fhit: assert property (st_wr && wcnt_q == W_FHIT |-> // [R10]
		mem_wdata_q == {3'h0, rx_q.data.filter_match_code, 8'h00})
		else $error("word 7 filter code wrong");
	a_full_set: assert property (s_store_last |=> // [R12]
		full_q[$past(rx_q.data.buf_idx)])
		else $error("full flag not set after store");
	a_full_hold: assert property (1'b1 |=> // [R12]
		(full_q & $past(full_q & ~clr_mask)) == $past(full_q & ~clr_mask))
		else $error("full flag dropped without clear");
	a_word_order: assert property (mem_req_q && mem_ack && // [R13]
		!(wcnt_q == W_FHIT || (!mem_we_q && wcnt_q == W_DATA_67)) |=>
		mem_req_q && wcnt_q == $past(wcnt_q) + 3'h1)
		else $error("buffer words out of order");
	a_fetch_frame: assert property (s_fetch_last |=> // [R13]
		tx_frame_valid_q && !mem_req_q && tx_frame_q.buf_idx == cur_buf_q)
		else $error("fetched frame not presented");
	a_fetch_dlc: assert property (state_q == ST_FETCH && mem_ack && // [R8]
		wcnt_q == W_EXT_LO |=> tx_frame_q.dlc == $past(mem_rdata[3:0]) &&
		tx_frame_q.rtr == $past(mem_rdata[9]))
		else $error("word 2 unpack wrong");
endmodule // cmb_msg_buffer

//--- test/cmb_mem_model.sv
`timescale 1ns/1ps
// Shared message memory behind the buffer engine, with settable wait time
module cmb_mem_model (
	// Clock
	input  wire logic                       core_clk,
	// Memory port
	input  wire logic                       mem_req,
	input  wire logic                       mem_we,
	input  wire logic [cmb_pkg::MEM_AW-1:0] mem_addr,
	input  wire logic [15:0]                mem_wdata,
	output logic      [15:0]                mem_rdata,
	output logic                            mem_ack,
	// Wait cycles before each acknowledge
	input  wire logic [3:0]                 lat
);
	import cmb_pkg::*;
	logic [15:0] mem [1024];  // Buffer area placed by software
	logic [3:0]  wait_q;

	initial begin
		mem_ack = 1'b0;
		mem_rdata = 16'h0000;
		wait_q = 4'h0;
	end

	always @(posedge core_clk) begin
		mem_ack <= 1'b0;
		// Read data is garbage outside the acknowledge cycle
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_ack) begin
			if (wait_q >= lat) begin
				wait_q <= 4'h0;
				mem_ack <= 1'b1;
				if (mem_we)
					mem[mem_addr] <= mem_wdata;
				else
					mem_rdata <= mem[mem_addr];
			end else begin
				wait_q <= wait_q + 4'h1;
			end
		end
	end
endmodule // cmb_mem_model

//--- test/cmb_msg_buffer_tb.sv
`timescale 1ns/1ps
module cmb_msg_buffer_tb;
	import cmb_pkg::*;
	localparam logic [9:0] BASE = 10'h040;
	logic        core_clk, arst_n, full_wr, rx_valid, rx_ready;
	logic        tx_req, tx_taken, tx_refused, tx_frame_valid;
	logic        tx_frame_ready, mem_req, mem_we, mem_ack, stalled;
	logic [31:0] dir, full_wdata, buffer_full_flag;
	logic [4:0]  tx_buf;
	logic [3:0]  lat;
	logic [9:0]  mem_addr;
	logic [15:0] mem_wdata, mem_rdata;
	cmb_frame_t  rx_frame, tx_frame, e;
	cmb_frame_t  fq [6];
	int          failures, n_checks, cycles;

	cmb_msg_buffer #(.NBUF(32)) u_dut (.core_clk(core_clk),
		.arst_n(arst_n), .buf_base(BASE), .buffer_direction_select(dir),
		.full_wr(full_wr), .full_wdata(full_wdata),
		.buffer_full_flag(buffer_full_flag), .rx_valid(rx_valid),
		.rx_frame(rx_frame), .rx_ready(rx_ready), .tx_req(tx_req),
		.tx_buf(tx_buf), .tx_taken(tx_taken), .tx_refused(tx_refused),
		.tx_frame_valid(tx_frame_valid), .tx_frame(tx_frame),
		.tx_frame_ready(tx_frame_ready), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.mem_ack(mem_ack));
	cmb_mem_model u_mem (.core_clk(core_clk), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack), .lat(lat));

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			results();
		end
	end

	task automatic results();
		$display("checks %0d, mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_frame(input cmb_frame_t got, input cmb_frame_t exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	function automatic logic [15:0] pack(input cmb_frame_t f, input int w);
		case (w)
			0: return {3'h0, f.std_id,
				f.subst_remote_req, f.ext_id_flag};
			1: return {4'h0, f.ext_id[17:6]};
			2: return {f.ext_id[5:0], f.rtr,
				1'b0, 3'h0, 1'b0, f.dlc};
			7: return {3'h0, f.filter_match_code, 8'h00};
			default: return f.data[16*(w-3) +: 16];
		endcase
	endfunction

	function automatic cmb_frame_t mk(input logic [4:0] b,
		input logic [63:0] p);
		cmb_frame_t f;
		f.buf_idx = b;
		f.std_id = p[10:0];
		f.ext_id = p[28:11];
		f.subst_remote_req = p[29];
		f.ext_id_flag = p[30];
		f.rtr = p[31];
		f.dlc = p[35:32];
		f.filter_match_code = p[40:36];
		f.data = {p[31:0], p[63:32]};
		return f;
	endfunction

	task automatic send(input cmb_frame_t f);
		rx_valid = 1'b1;
		rx_frame = f;
		for (int i = 0; i < 200 && rx_ready !== 1'b1; i++) begin
			stalled = 1'b1;
			@(negedge core_clk);
		end
		@(negedge core_clk);
	endtask

	task automatic wait_flag(input int b);
		for (int i = 0; i < 500 && buffer_full_flag[b] !== 1'b1; i++)
			@(negedge core_clk);
	endtask

	task automatic chk_buf(input cmb_frame_t f);
		for (int w = 0; w < 8; w++)
			cmp_word(u_mem.mem[BASE + {f.buf_idx, w[2:0]}], pack(f, w));
	endtask

	task automatic fetch(input logic [4:0] b, output logic taken);
		tx_buf = b;
		tx_req = 1'b1;
		for (int i = 0; i < 50 && !(tx_taken === 1'b1 || tx_refused === 1'b1); i++)
			@(negedge core_clk);
		taken = tx_taken;
		tx_req = 1'b0;
	endtask

	initial begin
		logic t;
		{arst_n, full_wr, rx_valid, tx_req, tx_frame_ready} = 5'h00;
		{full_wdata, tx_buf, lat, stalled} = '0;
		dir = 32'h0000_ff00;
		rx_frame = '0;
		repeat (20) @(negedge core_clk);
		arst_n = 1'b1;
		cmp_word(buffer_full_flag, 32'h0);
		cmp_word({rx_ready, mem_req, tx_frame_valid}, 32'h4);
		$display("test reset done");
		// Boundary patterns into the lowest and highest buffer
		fq[0] = mk(5'h00, 64'hffff_ffff_ffff_ffff);
		fq[1] = mk(5'h1f, 64'h0123_4567_89ab_cdef);
		send(fq[0]);
		send(fq[1]);
		rx_valid = 1'b0;
		wait_flag(31);
		chk_buf(fq[0]);
		chk_buf(fq[1]);
		$display("test store done");
		// Slow memory so that the two-entry buffer fills and refuses
		lat = 4'h7;
		for (int i = 2; i < 6; i++) begin
			fq[i] = mk(5'(i - 1), 64'h9e37_79b9_7f4a_7c15 * i);
			send(fq[i]);
		end
		rx_valid = 1'b0;
		wait_flag(4);
		for (int i = 2; i < 6; i++)
			chk_buf(fq[i]);
		cmp_word(stalled, 32'h1);
		cmp_word(buffer_full_flag, 32'h8000_001f);
		$display("test backlog done");
		full_wr = 1'b1;
		full_wdata = ~32'h2;
		@(negedge core_clk);
		full_wr = 1'b0;
		@(negedge core_clk);
		cmp_word(buffer_full_flag, 32'h8000_001d);
		$display("test flag clear done");
		// Fetch from a transmit buffer with a stalled consumer
		lat = 4'h3;
		e = mk(5'h09, 64'hc3a5_5a3c_0ff0_1e2d);
		e.filter_match_code = 5'h00;
		for (int w = 0; w < 7; w++)
			u_mem.mem[BASE + {5'h09, w[2:0]}] = pack(e, w);
		u_mem.mem[BASE + 10'h048] = pack(e, 0) | 16'he000;
		u_mem.mem[BASE + 10'h04f] = 16'hffff;
		fetch(5'h09, t);
		cmp_word(t, 32'h1);
		for (int i = 0; i < 200 && tx_frame_valid !== 1'b1; i++)
			@(negedge core_clk);
		repeat (4) @(negedge core_clk);
		cmp_word(tx_frame_valid, 32'h1);
		cmp_frame(tx_frame, e);
		tx_frame_ready = 1'b1;
		@(negedge core_clk);
		tx_frame_ready = 1'b0;
		cmp_word(tx_frame_valid, 32'h0);
		$display("test fetch done");
		// A receive buffer may not be fetched
		fetch(5'h1f, t);
		cmp_word({t, tx_refused}, 32'h1);
		repeat (3) @(negedge core_clk);
		cmp_word({mem_req, tx_frame_valid}, 32'h0);
		$display("test refuse done");
		results();
	end
endmodule // cmb_msg_buffer_tb
